/* File: keypad_defs.svh */
// Timing counts, key positions and menu limits for the keypad controller.
//
// Contract
// - Stop LED steady when stopped, flashes when faulted.
// - Run LED steady at speed, flashes while ramping.
// - Alarm LED flashes while any alarm is active.
// - Start key works only with keypad local source.
// - Editing: up increments digit or next enum entry.
// - Browsing: up selects next parameter, wraps to first.
// - Editing: down decrements digit or previous enum entry.
// - Browsing: down selects previous parameter, wraps to last.
// - Fault/event lists: up next, down previous entry.
// - Operate screen: up/down change meter group.
// - Left moves edit cursor left, wrapping around.
// - Menu mode: left cycles groups opposite to menu.
// - Enter commits the edited value.
// - Enter steps through recorded fault/event details.
// - Enter cycles through active alarms.
// - Menu cycles operate screen and parameter groups.
// - Menu while viewing returns to menu top.
// - Menu while editing discards change, shows old value.
// - Stop key commands the starter to halt.
// - Stop key clears a latched fault.
// - Stop honoured unless inhibited with non-keypad source; the code also honours it with remote source when inhibited.
`ifndef KEYPAD_DEFS_SVH
`define KEYPAD_DEFS_SVH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define KP_CLK_KHZ          100000
`define KP_BLINK_HALF_MS    250
`define KP_BLINK_HALF_CYC   (`KP_BLINK_HALF_MS * `KP_CLK_KHZ)
`define KP_DEBOUNCE_MS      10
`define KP_DEBOUNCE_CYC     (`KP_DEBOUNCE_MS * `KP_CLK_KHZ)

// ----------------------------------------------------------------
// Key bit positions in the raw key vector
// ----------------------------------------------------------------
`define KP_NUM_KEYS         7
`define KP_KEY_START        0
`define KP_KEY_STOP         1
`define KP_KEY_UP           2
`define KP_KEY_DOWN         3
`define KP_KEY_LEFT         4
`define KP_KEY_ENTER        5
`define KP_KEY_MENU         6

// ----------------------------------------------------------------
// Menu limits
// ----------------------------------------------------------------
`define KP_LAST_PARAM_GROUP 3'h5
`define KP_FAULT_GROUP      3'h6
`define KP_EVENT_GROUP      3'h7
`define KP_FAULT_LAST       7'h08
`define KP_EVENT_LAST       7'h62
`define KP_FAULT_STEP_LAST  7'h0A
`define KP_EVENT_STEP_LAST  7'h03
`define KP_METER_LAST       7'h12
`define KP_CURSOR_LAST      2'h3

`endif

/* File: keypad_pkg.sv */
// Types shared by the keypad controller modules.
package keypad_pkg;

	// Which screen the operator is looking at.
	typedef enum logic [2:0] {
		SCR_OPERATE   = 3'h0,
		SCR_GROUP     = 3'h1,
		SCR_EDIT      = 3'h2,
		SCR_FAULT_LOG = 3'h3,
		SCR_EVENT_LOG = 3'h4
	} screen_e;

	// State of the key debouncer.
	typedef struct packed {
		logic [20:0] tick_cnt;   // Sample divider.
		logic [6:0]  sync1;      // First synchroniser stage.
		logic [6:0]  sync2;      // Second synchroniser stage.
		logic [6:0]  sample;     // Previous tick sample.
		logic [6:0]  stable;     // Accepted key level.
		logic [6:0]  press;      // One-cycle press pulses.
	} debounce_s;

	// State of the LED blink generator.
	typedef struct packed {
		logic [24:0] cnt;        // Half-period counter.
		logic        phase;      // Blink phase, high means lit.
	} blink_s;

	// State of the menu interpreter.
	typedef struct packed {
		screen_e     screen;
		logic [2:0]  group;
		logic [6:0]  param_idx;
		logic [15:0] edit_value;
		logic [1:0]  cursor;
		logic [6:0]  fault_idx;
		logic [6:0]  event_idx;
		logic [6:0]  detail;
		logic [6:0]  meter;
		logic [6:0]  alarm_idx;
		logic        start_cmd;
		logic        stop_cmd;
		logic        fault_reset;
		logic        param_write;
		logic        led_stop;
		logic        led_run;
		logic        led_alarm;
	} menu_s;

endpackage : keypad_pkg

/* File: key_debounce.sv */
// Synchronises and debounces the seven keypad keys into one-cycle press pulses.
`timescale 1ns/1ps
`default_nettype none
`include "keypad_defs.svh"

module key_debounce #(
	parameter int DEBOUNCE_CYC = `KP_DEBOUNCE_CYC
) (
	// Clock and reset.
	input  wire logic       sys_clk_in,
	input  wire logic       rst_in,
	// Raw keys, high while pressed.
	input  wire logic [6:0] keys_in,
	// Debounced press pulses.
	output logic      [6:0] press_out
);

	keypad_pkg::debounce_s st;       // Registered state.
	keypad_pkg::debounce_s next_st;  // Next state.

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	// A level is accepted only when two samples one tick apart agree,
	// so bounce shorter than a tick never reaches the menu logic.
	always_comb begin
		next_st       = st;
		next_st.sync1 = keys_in;
		next_st.sync2 = st.sync1;
		next_st.press = 7'h00;
		if (st.tick_cnt == 21'(DEBOUNCE_CYC - 1)) begin
			next_st.tick_cnt = 21'h000000;
			next_st.sample   = st.sync2;
			for (int i = 0; i < `KP_NUM_KEYS; i++) begin
				if (st.sync2[i] == st.sample[i]) begin
					next_st.stable[i] = st.sync2[i];
					// Rising edge only: one action per press.
					next_st.press[i] = st.sync2[i] & ~st.stable[i];
				end
			end
		end else begin
			next_st.tick_cnt = st.tick_cnt + 21'h000001;
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign press_out = st.press;

endmodule : key_debounce
`default_nettype wire

/* File: led_blinker.sv */
// Free-running square wave used for every flashing LED.
`timescale 1ns/1ps
`default_nettype none
`include "keypad_defs.svh"

module led_blinker #(
	parameter int HALF_CYC = `KP_BLINK_HALF_CYC
) (
	// Clock and reset.
	input  wire logic sys_clk_in,
	input  wire logic rst_in,
	// Blink phase, high for the lit half.
	output logic      phase_out
);

	keypad_pkg::blink_s st;       // Registered state.
	keypad_pkg::blink_s next_st;  // Next state.

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	// One shared phase keeps all flashing LEDs in step.
	always_comb begin
		next_st = st;
		if (st.cnt == 25'(HALF_CYC - 1)) begin
			next_st.cnt   = 25'h0000000;
			next_st.phase = ~st.phase;
		end else begin
			next_st.cnt = st.cnt + 25'h0000001;
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign phase_out = st.phase;

endmodule : led_blinker
`default_nettype wire

/* File: keypad_led_menu_controller.sv */
// Front-panel key interpreter and status LED driver for the motor starter.
`timescale 1ns/1ps
`default_nettype none
`include "keypad_defs.svh"

module keypad_led_menu_controller #(
	parameter int DEBOUNCE_CYC = `KP_DEBOUNCE_CYC,
	parameter int BLINK_CYC    = `KP_BLINK_HALF_CYC
) (
	// Clock and reset.
	input  wire logic        sys_clk_in,
	input  wire logic        rst_in,
	// Raw keys from the keypad, high while pressed.
	input  wire logic [6:0]  keys_in,
	// Starter state.
	input  wire logic        stopped_in,
	input  wire logic        faulted_in,
	input  wire logic        running_in,
	input  wire logic        at_speed_in,
	input  wire logic        alarm_active_in,
	input  wire logic [6:0]  alarm_count_in,
	// Control settings.
	input  wire logic        local_control_source_in,
	input  wire logic        remote_control_source_in,
	input  wire logic        keypad_stop_inhibit_in,
	// Parameter store.
	input  wire logic [6:0]  param_count_in,
	input  wire logic        param_is_enum_in,
	input  wire logic [15:0] enum_count_in,
	input  wire logic [15:0] param_stored_in,
	// Starter commands.
	output logic             start_cmd_out,
	output logic             stop_cmd_out,
	output logic             fault_reset_out,
	// Parameter write.
	output logic             param_write_out,
	output logic [15:0]      param_value_out,
	// Display selection.
	output logic [2:0]       screen_out,
	output logic [2:0]       group_out,
	output logic [6:0]       param_index_out,
	output logic [1:0]       cursor_out,
	output logic [6:0]       fault_index_out,
	output logic [6:0]       event_index_out,
	output logic [6:0]       detail_step_out,
	output logic [6:0]       meter_page_out,
	output logic [6:0]       alarm_index_out,
	// Status LEDs.
	output logic             led_stop_out,
	output logic             led_run_out,
	output logic             led_alarm_out
);

	// ------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------
	// Step forward through 0..last, wrapping to 0.
	function automatic logic [6:0] wrap_inc(input logic [6:0] v, input logic [6:0] last);
		wrap_inc = (v >= last) ? 7'h00 : v + 7'h01;
	endfunction : wrap_inc

	// Step backward through 0..last, wrapping to last.
	function automatic logic [6:0] wrap_dec(input logic [6:0] v, input logic [6:0] last);
		wrap_dec = (v == 7'h00 || v > last) ? last : v - 7'h01;
	endfunction : wrap_dec

	// Add or take one from the BCD digit under the cursor, digit wraps 0..9.
	function automatic logic [15:0] bcd_step(input logic [15:0] v, input logic [1:0] pos,
		input logic up);
		logic [3:0]  d;
		logic [15:0] r;
		r = v;
		d = v[pos*4 +: 4];
		if (up) begin
			d = (d >= 4'h9) ? 4'h0 : d + 4'h1;
		end else begin
			d = (d == 4'h0 || d > 4'h9) ? 4'h9 : d - 4'h1;
		end
		r[pos*4 +: 4] = d;
		bcd_step = r;
	endfunction : bcd_step

	// ------------------------------------------------------------
	// Key conditioning and blink source
	// ------------------------------------------------------------
	logic [6:0] press;        // One-cycle debounced press pulses.
	logic       blink;        // Shared blink phase.
	logic       key_start;    // Decoded presses.
	logic       key_stop;
	logic       key_up;
	logic       key_down;
	logic       key_left;
	logic       key_enter;
	logic       key_menu;
	logic [6:0] param_last;   // Index of last parameter in group.
	logic [6:0] alarm_last;   // Index of last active alarm.
	logic [15:0] enum_last;   // Last enumerated entry.

	key_debounce #(.DEBOUNCE_CYC(DEBOUNCE_CYC)) u_debounce (
		.sys_clk_in (sys_clk_in),
		.rst_in     (rst_in),
		.keys_in    (keys_in),
		.press_out  (press)
	);

	led_blinker #(.HALF_CYC(BLINK_CYC)) u_blinker (
		.sys_clk_in (sys_clk_in),
		.rst_in     (rst_in),
		.phase_out  (blink)
	);

	assign key_start  = press[`KP_KEY_START];
	assign key_stop   = press[`KP_KEY_STOP];
	assign key_up     = press[`KP_KEY_UP];
	assign key_down   = press[`KP_KEY_DOWN];
	assign key_left   = press[`KP_KEY_LEFT];
	assign key_enter  = press[`KP_KEY_ENTER];
	assign key_menu   = press[`KP_KEY_MENU];
	assign param_last = (param_count_in == 7'h00) ? 7'h00 : param_count_in - 7'h01;
	assign alarm_last = (alarm_count_in == 7'h00) ? 7'h00 : alarm_count_in - 7'h01;
	assign enum_last  = (enum_count_in == 16'h0000) ? 16'h0000 : enum_count_in - 16'h0001;

	// ------------------------------------------------------------
	// Menu state
	// ------------------------------------------------------------
	keypad_pkg::menu_s st;       // Registered state.
	keypad_pkg::menu_s next_st;  // Next state.

	// All key handling and LED decoding in one place. Keys arrive as
	// single pulses, so each press changes the state exactly once.
	always_comb begin
		next_st             = st;
		next_st.start_cmd   = 1'b0;
		next_st.stop_cmd    = 1'b0;
		next_st.fault_reset = 1'b0;
		next_st.param_write = 1'b0;

		// Start only from the keypad as local source.
		next_st.start_cmd = key_start & local_control_source_in;
		// Stop always halts under local or remote source, otherwise unless inhibited.
		next_st.stop_cmd = key_stop & (local_control_source_in | remote_control_source_in
			| ~keypad_stop_inhibit_in);
		// A latched fault is cleared by the stop key regardless of source.
		next_st.fault_reset = key_stop & faulted_in;

		case (st.screen)
			keypad_pkg::SCR_OPERATE: begin
				if (key_up) begin
					next_st.meter = wrap_inc(st.meter, `KP_METER_LAST);
				end else if (key_down) begin
					next_st.meter = wrap_dec(st.meter, `KP_METER_LAST);
				end else if (key_enter && alarm_active_in) begin
					next_st.alarm_idx = wrap_inc(st.alarm_idx, alarm_last);
				end else if (key_menu) begin
					next_st.screen    = keypad_pkg::SCR_GROUP;
					next_st.group     = 3'h0;
					next_st.param_idx = 7'h00;
				end else if (key_left) begin
					next_st.screen = keypad_pkg::SCR_EVENT_LOG;
					next_st.group  = `KP_EVENT_GROUP;
					next_st.detail = 7'h00;
				end
			end
			keypad_pkg::SCR_GROUP: begin
				if (key_up) begin
					next_st.param_idx = wrap_inc(st.param_idx, param_last);
				end else if (key_down) begin
					next_st.param_idx = wrap_dec(st.param_idx, param_last);
				end else if (key_enter) begin
					next_st.screen     = keypad_pkg::SCR_EDIT;
					next_st.edit_value = param_stored_in;
					next_st.cursor     = 2'h0;
				end else if (key_menu && st.param_idx != 7'h00) begin
					next_st.param_idx = 7'h00;
				end else if (key_menu) begin
					// Next group; the last parameter group leads to the logs.
					next_st.param_idx = 7'h00;
					if (st.group == `KP_LAST_PARAM_GROUP) begin
						next_st.screen = keypad_pkg::SCR_FAULT_LOG;
						next_st.group  = `KP_FAULT_GROUP;
						next_st.detail = 7'h00;
					end else begin
						next_st.group = st.group + 3'h1;
					end
				end else if (key_left) begin
					next_st.param_idx = 7'h00;
					if (st.group == 3'h0) begin
						next_st.screen = keypad_pkg::SCR_OPERATE;
					end else begin
						next_st.group = st.group - 3'h1;
					end
				end
			end
			keypad_pkg::SCR_EDIT: begin
				if (key_up) begin
					if (param_is_enum_in) begin
						next_st.edit_value = (st.edit_value >= enum_last) ? 16'h0000
							: st.edit_value + 16'h0001;
					end else begin
						next_st.edit_value = bcd_step(st.edit_value, st.cursor, 1'b1);
					end
				end else if (key_down) begin
					if (param_is_enum_in) begin
						next_st.edit_value = (st.edit_value == 16'h0000) ? enum_last
							: st.edit_value - 16'h0001;
					end else begin
						next_st.edit_value = bcd_step(st.edit_value, st.cursor, 1'b0);
					end
				end else if (key_left && !param_is_enum_in) begin
					// Toward the most significant digit, then back to the least.
					next_st.cursor = (st.cursor == `KP_CURSOR_LAST) ? 2'h0
						: st.cursor + 2'h1;
				end else if (key_enter) begin
					next_st.param_write = 1'b1;
					next_st.screen      = keypad_pkg::SCR_GROUP;
				end else if (key_menu) begin
					// Pending value dropped; display falls back to the stored one.
					next_st.screen = keypad_pkg::SCR_GROUP;
				end
			end
			keypad_pkg::SCR_FAULT_LOG, keypad_pkg::SCR_EVENT_LOG: begin
				if (key_up) begin
					next_st.detail = 7'h00;
					if (st.screen == keypad_pkg::SCR_FAULT_LOG) begin
						next_st.fault_idx = wrap_inc(st.fault_idx, `KP_FAULT_LAST);
					end else begin
						next_st.event_idx = wrap_inc(st.event_idx, `KP_EVENT_LAST);
					end
				end else if (key_down) begin
					next_st.detail = 7'h00;
					if (st.screen == keypad_pkg::SCR_FAULT_LOG) begin
						next_st.fault_idx = wrap_dec(st.fault_idx, `KP_FAULT_LAST);
					end else begin
						next_st.event_idx = wrap_dec(st.event_idx, `KP_EVENT_LAST);
					end
				end else if (key_enter) begin
					next_st.detail = wrap_inc(st.detail,
						(st.screen == keypad_pkg::SCR_FAULT_LOG) ? `KP_FAULT_STEP_LAST
						: `KP_EVENT_STEP_LAST);
				end else if (key_menu) begin
					next_st.detail = 7'h00;
					if (st.screen == keypad_pkg::SCR_FAULT_LOG) begin
						next_st.screen = keypad_pkg::SCR_EVENT_LOG;
						next_st.group  = `KP_EVENT_GROUP;
					end else begin
						next_st.screen = keypad_pkg::SCR_OPERATE;
					end
				end else if (key_left) begin
					next_st.detail = 7'h00;
					if (st.screen == keypad_pkg::SCR_EVENT_LOG) begin
						next_st.screen = keypad_pkg::SCR_FAULT_LOG;
						next_st.group  = `KP_FAULT_GROUP;
					end else begin
						next_st.screen    = keypad_pkg::SCR_GROUP;
						next_st.group     = `KP_LAST_PARAM_GROUP;
						next_st.param_idx = 7'h00;
					end
				end
			end
			default: begin
				next_st.screen = keypad_pkg::SCR_OPERATE;
			end
		endcase

		// Without alarms the alarm cursor restarts at the first one.
		if (!alarm_active_in) begin
			next_st.alarm_idx = 7'h00;
		end

		// Fault outranks stopped so a trip is never shown as a clean stop.
		next_st.led_stop  = faulted_in ? blink : stopped_in;
		next_st.led_run   = running_in & (at_speed_in | blink);
		next_st.led_alarm = alarm_active_in & blink;
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign start_cmd_out   = st.start_cmd;
	assign stop_cmd_out    = st.stop_cmd;
	assign fault_reset_out = st.fault_reset;
	assign param_write_out = st.param_write;
	// Outside editing and the write pulse the stored value is shown, so an abort reverts it.
	assign param_value_out = (st.screen == keypad_pkg::SCR_EDIT || st.param_write)
		? st.edit_value : param_stored_in;
	assign screen_out      = st.screen;
	assign group_out       = st.group;
	assign param_index_out = st.param_idx;
	assign cursor_out      = st.cursor;
	assign fault_index_out = st.fault_idx;
	assign event_index_out = st.event_idx;
	assign detail_step_out = st.detail;
	assign meter_page_out  = st.meter;
	assign alarm_index_out = st.alarm_idx;
	assign led_stop_out    = st.led_stop;
	assign led_run_out     = st.led_run;
	assign led_alarm_out   = st.led_alarm;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	sequence s_editing;
		st.screen == keypad_pkg::SCR_EDIT;
	endsequence

	sequence s_edit_key(logic k);
		s_editing ##0 k;
	endsequence

	AST_START_GATED: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		key_start |=> start_cmd_out == $past(local_control_source_in))
		else $error("Start command does not follow local source.");

	AST_STOP_HONOURED: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		key_stop && (local_control_source_in || !keypad_stop_inhibit_in) |=> stop_cmd_out)
		else $error("Stop key not honoured.");

	AST_FAULT_RESET: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		fault_reset_out |-> $past(key_stop) && $past(faulted_in))
		else $error("Fault reset without stop press on a fault.");

	AST_COMMIT: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		s_edit_key(key_enter) |=> param_write_out && screen_out == 3'h1)
		else $error("Enter did not commit the edit.");

	AST_ABORT: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		s_edit_key(key_menu) ##0 !key_enter |=> !param_write_out
		&& param_value_out == param_stored_in)
		else $error("Menu during edit did not restore stored value.");

	AST_CURSOR_WRAP: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		s_edit_key(key_left) ##0 !param_is_enum_in && cursor_out == 2'h3
		|=> cursor_out == 2'h0)
		else $error("Cursor did not wrap to least significant digit.");

	AST_PARAM_WRAP: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		st.screen == keypad_pkg::SCR_GROUP && key_up && param_index_out == param_last
		|=> param_index_out == 7'h00)
		else $error("Parameter index did not wrap to first.");

	AST_LED_STOP: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		!faulted_in && stopped_in ##1 !faulted_in && stopped_in |-> led_stop_out)
		else $error("Stop LED not steady while stopped.");

	AST_LED_ALARM: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		!$past(alarm_active_in) |-> !led_alarm_out)
		else $error("Alarm LED lit without alarm.");

	AST_ONE_PULSE: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		param_write_out |=> !param_write_out)
		else $error("Parameter write lasted more than one cycle.");

endmodule : keypad_led_menu_controller
`default_nettype wire

/* File: key_operator.sv */
// Operator model that presses and releases one keypad key at a time.
`timescale 1ns/1ps
`default_nettype none

module key_operator (
	// Clock.
	input  wire logic      sys_clk_in,
	// Key levels toward the controller, high while pressed.
	output var logic [6:0] keys_out
);
	// No key is touched until asked.
	initial keys_out = 7'h00;

	// A press is held 20 cycles and released 20, five debounce ticks of 4 cycles each way, so each press is one action.
	task automatic press(input int k);
		@(posedge sys_clk_in);
		#1 keys_out[k] = 1'h1;
		repeat (20) @(posedge sys_clk_in);
		#1 keys_out[k] = 1'h0;
		repeat (20) @(posedge sys_clk_in);
		#1;
	endtask : press
endmodule : key_operator

`default_nettype wire

/* File: keypad_led_menu_controller_bench.sv */
// Self-checking bench for the keypad controller.
`timescale 1ns/1ps
`default_nettype none
`include "keypad_defs.svh"

module keypad_led_menu_controller_bench;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	localparam int k_st = `KP_KEY_START, k_sp = `KP_KEY_STOP, k_up = `KP_KEY_UP;
	localparam int k_dn = `KP_KEY_DOWN, k_lf = `KP_KEY_LEFT, k_en = `KP_KEY_ENTER;
	localparam int k_mn = `KP_KEY_MENU;
	logic        clk, rst, stp, flt, run, spd, alm, loc, rem, inh, en;
	logic        st_c, sp_c, fr_c, pw, ls, lr, la;
	logic [6:0]  keys, pc, pidx, meter, fidx, eidx, det, aidx;
	logic [15:0] stored, pv, wv;
	logic [2:0]  scr, grp;
	logic [1:0]  cur;
	int          miscompares = 0, n_compared = 0, n_st = 0, n_sp = 0, n_fr = 0, n_wr = 0;

	key_operator op (.sys_clk_in(clk), .keys_out(keys));

	keypad_led_menu_controller #(.DEBOUNCE_CYC(4), .BLINK_CYC(8)) dut (
		.sys_clk_in(clk), .rst_in(rst), .keys_in(keys), .stopped_in(stp),
		.faulted_in(flt), .running_in(run), .at_speed_in(spd), .alarm_active_in(alm),
		.alarm_count_in(7'h03), .local_control_source_in(loc),
		.remote_control_source_in(rem), .keypad_stop_inhibit_in(inh),
		.param_count_in(pc), .param_is_enum_in(en), .enum_count_in(16'h0005),
		.param_stored_in(stored), .start_cmd_out(st_c), .stop_cmd_out(sp_c),
		.fault_reset_out(fr_c), .param_write_out(pw), .param_value_out(pv),
		.screen_out(scr), .group_out(grp), .param_index_out(pidx), .cursor_out(cur),
		.fault_index_out(fidx), .event_index_out(eidx), .detail_step_out(det),
		.meter_page_out(meter), .alarm_index_out(aidx), .led_stop_out(ls),
		.led_run_out(lr), .led_alarm_out(la));

	// Clock of 10 ns.
	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end

	// Command pulses are counted, and the written value caught at its pulse.
	always @(posedge clk) begin
		n_st += (st_c !== 1'h0);
		n_sp += (sp_c !== 1'h0);
		n_fr += (fr_c !== 1'h0);
		n_wr += (pw !== 1'h0);
		if (pw === 1'h1) wv <= pv;
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// A blinking LED is lit for exactly half of 32 cycles at a half period of 8.
	task automatic leds(input int s, input int r, input int a);
		int cs, cr, ca;
		cs = 0; cr = 0; ca = 0;
		repeat (2) @(posedge clk);
		repeat (32) begin
			@(posedge clk);
			#1 cs += (ls === 1'h1); cr += (lr === 1'h1); ca += (la === 1'h1);
		end
		chk("led_stop", s, cs);
		chk("led_run", r, cr);
		chk("led_alarm", a, ca);
	endtask : leds

	task automatic stop_test;
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : stop_test

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_leds;
		leds(32, 0, 0);
		flt = 1'h1;
		leds(16, 0, 0);
		{stp, flt, run, alm} = 4'h3;
		leds(0, 16, 16);
		spd = 1'h1;
		leds(0, 32, 16);
		{stp, run, spd, alm} = 4'h8;
	endtask : t_leds

	task automatic t_cmds;
		op.press(k_st);
		chk("start", 1, n_st);
		loc = 1'h0;
		op.press(k_st);
		chk("start", 1, n_st);
		op.press(k_sp);
		chk("stop", 1, n_sp);
		inh = 1'h1;
		op.press(k_sp);
		chk("stop", 1, n_sp);
		rem = 1'h1;
		flt = 1'h1;
		op.press(k_sp);
		chk("stop", 2, n_sp);
		chk("fault_reset", 1, n_fr);
		flt = 1'h0;
		rem = 1'h0;
		loc = 1'h1;
		op.press(k_sp);
		chk("stop", 3, n_sp);
		chk("fault_reset", 1, n_fr);
	endtask : t_cmds

	task automatic t_menu;
		op.press(k_mn);
		chk("screen", 1, scr);
		op.press(k_dn);
		chk("param", 2, pidx);
		op.press(k_up);
		chk("param", 0, pidx);
		op.press(k_up);
		op.press(k_mn);
		chk("param", 0, pidx);
		chk("group", 0, grp);
		op.press(k_mn);
		chk("group", 1, grp);
		op.press(k_lf);
		chk("group", 0, grp);
		op.press(k_lf);
		chk("screen", 0, scr);
		op.press(k_up);
		chk("meter", 1, meter);
		repeat (2) op.press(k_dn);
		chk("meter", 18, meter);
	endtask : t_menu

	task automatic t_edit;
		op.press(k_mn);
		op.press(k_en);
		chk("screen", 2, scr);
		op.press(k_up);
		chk("value", 16'h1235, pv);
		op.press(k_lf);
		chk("cursor", 1, cur);
		op.press(k_dn);
		chk("value", 16'h1225, pv);
		op.press(k_en);
		chk("written", 16'h1225, wv);
		chk("writes", 1, n_wr);
		op.press(k_en);
		op.press(k_up);
		repeat (4) op.press(k_lf);
		chk("cursor", 0, cur);
		op.press(k_mn);
		chk("screen", 1, scr);
		chk("writes", 1, n_wr);
		chk("value", 16'h1234, pv);
		stored = 16'h0004;
		en = 1'h1;
		op.press(k_en);
		op.press(k_up);
		chk("enum", 0, pv);
		op.press(k_dn);
		chk("enum", 4, pv);
		op.press(k_lf);
		chk("cursor", 0, cur);
		op.press(k_mn);
		en = 1'h0;
	endtask : t_edit

	task automatic t_logs;
		repeat (2) op.press(k_lf);
		chk("screen", 4, scr);
		op.press(k_up);
		chk("event", 1, eidx);
		repeat (2) op.press(k_dn);
		chk("event", 98, eidx);
		op.press(k_en);
		chk("detail", 1, det);
		op.press(k_lf);
		chk("screen", 3, scr);
		op.press(k_dn);
		chk("fault", 8, fidx);
		repeat (2) op.press(k_mn);
		chk("screen", 0, scr);
		alm = 1'h1;
		op.press(k_en);
		chk("alarm", 1, aidx);
		repeat (2) op.press(k_en);
		chk("alarm", 0, aidx);
		alm = 1'h0;
	endtask : t_logs

	task automatic t_reset;
		rst = 1'h1;
		@(posedge clk);
		#1 rst = 1'h0;
		repeat (2) @(posedge clk);
		#1 chk("meter", 0, meter);
		chk("fault", 0, fidx);
	endtask : t_reset

	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial begin
		rst = 1'h1;
		{stp, flt, run, spd, alm, loc, rem, inh} = 8'h84;
		en = 1'h0;
		stored = 16'h1234;
		pc = 7'h03;
		repeat (3) @(posedge clk);
		#1 rst = 1'h0;
		t_leds();
		t_cmds();
		t_menu();
		t_edit();
		t_logs();
		t_reset();
		stop_test();
	end

	initial begin
		#100us;
		miscompares++;
		stop_test();
	end
endmodule : keypad_led_menu_controller_bench

`default_nettype wire
